/* hw/rcg_cfg.svh */
`ifndef RCG_CFG_SVH
`define RCG_CFG_SVH
// system clock
`define CLK_HZ          20000000
// gain span and step size, in dB
`define AGC_SPAN_DB     15
`define AGC_STEP_DB     1
`define AGC_EXT_DB      6
// full ramp times, in microseconds
`define UP_RAMP_US      10000
`define DOWN_RAMP_US    200
// regulation target of the equalizer outputs, mV peak-to-peak
`define TARGET_MVPP     1100
// gain step codes
`define GAIN_MIN        5'h00
`define GAIN_MAX        5'h0F
`define GAIN_MAX_EXT    5'h15
`define GAIN_RESET      5'h00
// one gain step of one dB
`define GAIN_STEP       5'h01
// sense current full scale, mA
`define SENSE_FS_MA     15
`define SENSE_FS_X2_MA  30
`define SENSE_OFF_CODE  7'h00
// source and preamp select codes
`define SRC_SERVO_CODE  2'h0
`define SRC_MAIN_CODE   2'h1
`define SRC_BIASFB_CODE 2'h2
`define PG_40DB_CODE    2'h0
`define PG_34DB_CODE    2'h1
// derived cycles per 1 dB step, rounded down
`define UP_STEP_CYC   ((`UP_RAMP_US * (`CLK_HZ / 1000000)) / (`AGC_SPAN_DB / `AGC_STEP_DB))
`define DOWN_STEP_CYC ((`DOWN_RAMP_US * (`CLK_HZ / 1000000)) / (`AGC_SPAN_DB / `AGC_STEP_DB))
`endif

/* hw/rcg_pkg.sv */
`default_nettype none
package rcg_pkg;
    // control bits written by software
    typedef struct packed {
        logic       manual_gain_select;
        logic [3:0] manual_gain;
        logic       gain_ceiling_extend;
        logic       vga_source_sel1;
        logic       vga_source_sel0;
        logic       freeze_pin_role;
        logic       hpf_enable;
        logic       filter_corner_sel1;
        logic       filter_corner_sel0;
        logic [1:0] preamp_gain_sel;
        logic [6:0] sense_code;
        logic       bias_current_range_x2;
        logic       bias_current_on;
    } ctrl_t;
    // amplitude comparator results
    typedef struct packed {
        logic amp_too_small;
        logic amp_too_large;
    } level_t;
    typedef enum logic [2:0] {
        SRC_MAIN   = 3'h1,
        SRC_BIASFB = 3'h2,
        SRC_SERVO  = 3'h4
    } vga_src_t;
    typedef enum logic [1:0] {
        PG_40DB      = 2'h0,
        PG_34DB      = 2'h1,
        PG_4DB_TEST  = 2'h2
    } preamp_t;
    typedef enum logic [1:0] {
        FC_1MHZ  = 2'h0,
        FC_2MHZ  = 2'h1,
        FC_4MHZ  = 2'h2,
        FC_10MHZ = 2'h3
    } corner_t;
    typedef enum logic [3:0] {
        ST_MANUAL = 4'h1,
        ST_TRACK  = 4'h2,
        ST_HOLD   = 4'h4,
        ST_SERVO  = 4'h8
    } agc_state_t;
    // analog settings driven out
    typedef struct packed {
        logic [4:0] gain_step;
        logic       servo_active;
        logic       agc_frozen;
        vga_src_t   vga_src;
        preamp_t    preamp;
        corner_t    corner;
        logic       hpf_on;
        logic       sense_on;
        logic       sense_range_x2;
        logic [6:0] sense_code;
    } out_t;
endpackage : rcg_pkg
`default_nettype wire

/* hw/step_timer.sv */
`default_nettype none
module step_timer #(
    parameter int INTERVAL = 266
) (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic run,
    output var  logic tick
);
    localparam int CW = $clog2(INTERVAL + 1);
    // counter and tick flop
    typedef struct packed {
        logic [CW-1:0] cnt_q;
        logic          tick_q;
    } tmr_t;
    tmr_t q;
    tmr_t d;
    ////////////////////////////////////////////////////////////////
    // restart when idle, pulse once per full interval
    always_comb
    begin
        d        = q;
        d.tick_q = 1'h0;
        if (!run)
            d.cnt_q = '0;
        else if (q.cnt_q == CW'(INTERVAL - 1))
        begin
            d.cnt_q  = '0;
            d.tick_q = 1'h1;
        end
        else
            d.cnt_q = q.cnt_q + 1'h1;
    end
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            q <= '0;
        else
            q <= d;
    end
    assign tick = q.tick_q;
endmodule : step_timer
`default_nettype wire

/* hw/read_channel_gain_control.sv */
// Summary of operation
// RQ1 - gain spans 15 dB in 1 dB steps
// RQ2 - too small: min to max in 10 ms
// RQ3 - too large: max to min in 0.2 ms
// RQ4 - ceiling extend bit adds 6 dB on top
// RQ5 - freeze pin low, writing, servo hold gain
// RQ6 - auto only when pin high, manual clear
// RQ7 - loop regulates outputs toward 1.1 Vpp
// RQ8 - both source select bits clear: servo
// RQ9 - role bit set before pin falls: servo
// RQ10 - servo forces max gain, keeps stored gain
// RQ11 - vga source: main, bias/feedback, servo
// RQ12 - preamp 40 or 34 dB, 4 dB test
// RQ13 - one select sets both filter corners
// RQ14 - high-pass differentiator can be bypassed
// RQ15 - 7-bit sense code, 0 to 15 mA
// RQ16 - range-double bit gives 30 mA full scale
// RQ17 - enable bit clear turns sense current off
// RQ18 - role bit picks freeze or servo pin use
// RQ19 - corner codes 1, 2, 4, 10 MHz
// RQ20 - gain saturates, step timing from clock
`include "rcg_cfg.svh"
`default_nettype none
module read_channel_gain_control #(
    parameter int UP_STEP_CYC   = `UP_STEP_CYC,
    parameter int DOWN_STEP_CYC = `DOWN_STEP_CYC
) (
    input  wire logic            CLK_SYS,
    input  wire logic            RESET_N,
    input  wire rcg_pkg::ctrl_t  CTRL,
    input  wire rcg_pkg::level_t LEVEL,
    input  wire logic            FREEZE_N,
    input  wire logic            WRITE_WINDOW_N,
    output var  rcg_pkg::out_t   STATUS
);
    import rcg_pkg::*;

    ////////////////////////////////////////////////////////////////
    // state of the block

    typedef struct packed {
        agc_state_t agc_state;   // loop mode
        logic [4:0] gain_q;      // stored gain step
        logic       pin_q;       // freeze pin, last cycle
        logic       pin_servo_q; // servo chosen by pin
        out_t       out;         // registered outputs
    } st_t;

    st_t q;                      // current state
    st_t d;                      // next state

    logic up_tick;               // one up step due
    logic down_tick;             // one down step due
    logic up_run;                // up interval running
    logic down_run;              // down interval running
    logic [4:0] ceiling;         // present gain ceiling
    logic sel_servo;             // source bits both clear
    logic pin_fall;              // freeze pin falling
    logic pin_hold;              // pin in freeze role, low
    logic writing;               // write window open

    ////////////////////////////////////////////////////////////////
    // decode helpers

    // source select bits to vga input
    function automatic vga_src_t src_decode(input logic s1, input logic s0);
        case ({s1, s0})
            `SRC_SERVO_CODE:  src_decode = SRC_SERVO;
            `SRC_MAIN_CODE:   src_decode = SRC_MAIN;
            `SRC_BIASFB_CODE: src_decode = SRC_BIASFB;
            default:          src_decode = SRC_MAIN;
        endcase
    endfunction : src_decode

    // preamp select bits to gain choice
    function automatic preamp_t pg_decode(input logic [1:0] s);
        case (s)
            `PG_40DB_CODE: pg_decode = PG_40DB;
            `PG_34DB_CODE: pg_decode = PG_34DB;
            default:       pg_decode = PG_4DB_TEST;
        endcase
    endfunction : pg_decode

    ////////////////////////////////////////////////////////////////
    // step interval timers

    // slow upward interval, one dB per tick
    step_timer #(
        .INTERVAL (UP_STEP_CYC)
    ) u_up_timer (
        .clk_sys (CLK_SYS),
        .reset_n (RESET_N),
        .run     (up_run),
        .tick    (up_tick)
    );

    // fast downward interval, one dB per tick
    step_timer #(
        .INTERVAL (DOWN_STEP_CYC)
    ) u_down_timer (
        .clk_sys (CLK_SYS),
        .reset_n (RESET_N),
        .run     (down_run),
        .tick    (down_tick)
    );

    ////////////////////////////////////////////////////////////////
    // combinational terms

    always_comb
    begin
        // ceiling moves up 6 dB when extended
        ceiling   = CTRL.gain_ceiling_extend ? `GAIN_MAX_EXT : `GAIN_MAX; // RQ1 RQ4
        sel_servo = ({CTRL.vga_source_sel1, CTRL.vga_source_sel0}
                     == `SRC_SERVO_CODE);                                 // RQ8
        pin_fall  = q.pin_q & ~FREEZE_N;
        pin_hold  = ~CTRL.freeze_pin_role & ~FREEZE_N;                    // RQ18
        writing   = ~WRITE_WINDOW_N;
        // too large wins over too small
        down_run  = (q.agc_state == ST_TRACK) & LEVEL.amp_too_large;      // RQ7
        up_run    = (q.agc_state == ST_TRACK) & LEVEL.amp_too_small
                    & ~LEVEL.amp_too_large;                               // RQ7
    end

    ////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        d       = q;
        d.pin_q = FREEZE_N;
        // pin servo only if role was set as the pin fell
        if (!CTRL.freeze_pin_role || FREEZE_N)
            d.pin_servo_q = 1'h0;                                         // RQ18
        else if (pin_fall)
            d.pin_servo_q = 1'h1;                                         // RQ9

        // mode choice, servo first
        if (sel_servo || d.pin_servo_q)
            d.agc_state = ST_SERVO;                                       // RQ5
        else if (CTRL.manual_gain_select)
            d.agc_state = ST_MANUAL;                                      // RQ6
        else if (pin_hold || writing)
            d.agc_state = ST_HOLD;                                        // RQ5
        else
            d.agc_state = ST_TRACK;                                       // RQ6

        case (d.agc_state)
            // software value taken as is
            ST_MANUAL:
            begin
                d.gain_q = {1'h0, CTRL.manual_gain};                      // RQ6
            end
            // clocked internal adaptation
            ST_TRACK:
            begin
                if (q.gain_q > ceiling)
                    d.gain_q = ceiling;                                   // RQ20
                else if (down_tick && down_run && q.gain_q > `GAIN_MIN)
                    d.gain_q = q.gain_q - `GAIN_STEP;                     // RQ3
                else if (up_tick && up_run && q.gain_q < ceiling)
                    d.gain_q = q.gain_q + `GAIN_STEP;                     // RQ2
                else
                    d.gain_q = q.gain_q;                                  // RQ20
            end
            // frozen: stored gain untouched
            ST_HOLD:
            begin
                d.gain_q = q.gain_q;                                      // RQ5
            end
            // servo: stored gain kept for later
            ST_SERVO:
            begin
                d.gain_q = q.gain_q;                                      // RQ10
            end
            default:
            begin
                d.agc_state = ST_HOLD;
                d.gain_q    = q.gain_q;
            end
        endcase

        // applied gain, forced to max in servo
        d.out.servo_active = (d.agc_state == ST_SERVO);                   // RQ8
        d.out.gain_step    = d.out.servo_active ? `GAIN_MAX_EXT : d.gain_q; // RQ10
        d.out.agc_frozen   = (d.agc_state == ST_HOLD)
                             || (d.agc_state == ST_SERVO);                // RQ5
        // analog path selections
        d.out.vga_src  = d.out.servo_active ? SRC_SERVO
                         : src_decode(CTRL.vga_source_sel1,
                                      CTRL.vga_source_sel0);              // RQ11
        d.out.preamp   = pg_decode(CTRL.preamp_gain_sel);                 // RQ12
        d.out.corner   = corner_t'({CTRL.filter_corner_sel1,
                                    CTRL.filter_corner_sel0});            // RQ13 RQ19
        d.out.hpf_on   = CTRL.hpf_enable;                                 // RQ14
        // sense current source
        d.out.sense_on       = CTRL.bias_current_on;                      // RQ17
        d.out.sense_range_x2 = CTRL.bias_current_range_x2;                // RQ16
        d.out.sense_code     = CTRL.bias_current_on ? CTRL.sense_code
                               : `SENSE_OFF_CODE;                         // RQ15 RQ17
    end

    ////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge CLK_SYS or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            q                      <= '0;
            q.agc_state            <= ST_HOLD;
            q.gain_q               <= `GAIN_RESET;
            q.pin_q                <= 1'h1;
            q.out.vga_src          <= SRC_SERVO;
            q.out.servo_active     <= 1'h1;
            q.out.agc_frozen       <= 1'h1;
            q.out.gain_step        <= `GAIN_MAX_EXT;
            q.out.sense_code       <= `SENSE_OFF_CODE;
        end
        else
            q <= d;
    end

    // outputs straight from the flops
    assign STATUS = q.out;

    ////////////////////////////////////////////////////////////////
    // checks

    // role bit set and pin falling
    sequence s_pin_fall;
        CTRL.freeze_pin_role && q.pin_q && !FREEZE_N;
    endsequence

    // an up step is due in tracking
    sequence s_up_due;
        q.agc_state == ST_TRACK && up_tick && up_run
        && q.gain_q < ceiling && d.agc_state == ST_TRACK;
    endsequence

    // a down step is due in tracking
    sequence s_down_due;
        q.agc_state == ST_TRACK && down_tick && down_run
        && q.gain_q > `GAIN_MIN && d.agc_state == ST_TRACK;
    endsequence

    property p_up_step;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        s_up_due |=> q.gain_q == $past(q.gain_q) + `GAIN_STEP;
    endproperty
    a_up_step: assert property (p_up_step)  // RQ2
        else $error("gain did not rise one step");

    property p_down_step;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        s_down_due |=> q.gain_q == $past(q.gain_q) - `GAIN_STEP;
    endproperty
    a_down_step: assert property (p_down_step)  // RQ3
        else $error("gain did not fall one step");

    property p_ceiling;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (!CTRL.gain_ceiling_extend && !CTRL.manual_gain_select
         && q.gain_q <= `GAIN_MAX) |=> q.gain_q <= `GAIN_MAX;
    endproperty
    a_ceiling: assert property (p_ceiling)  // RQ4
        else $error("gain passed the plain ceiling");

    property p_freeze;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (d.agc_state == ST_HOLD || d.agc_state == ST_SERVO)
        |=> $stable(q.gain_q) && STATUS.agc_frozen;
    endproperty
    a_freeze: assert property (p_freeze)  // RQ5
        else $error("gain moved while frozen");

    property p_manual;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (CTRL.manual_gain_select && !sel_servo && !d.pin_servo_q)
        |=> q.gain_q == {1'h0, $past(CTRL.manual_gain)};
    endproperty
    a_manual: assert property (p_manual)  // RQ6
        else $error("manual gain not applied");

    property p_sel_servo;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        sel_servo |=> STATUS.servo_active && STATUS.vga_src == SRC_SERVO;
    endproperty
    a_sel_servo: assert property (p_sel_servo)  // RQ8
        else $error("select bits did not enter servo");

    property p_pin_servo;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        s_pin_fall ##1 (!FREEZE_N && CTRL.freeze_pin_role) |-> STATUS.servo_active;
    endproperty
    a_pin_servo: assert property (p_pin_servo)  // RQ9
        else $error("pin did not enter servo");

    property p_servo_max;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        STATUS.servo_active |-> STATUS.gain_step == `GAIN_MAX_EXT;
    endproperty
    a_servo_max: assert property (p_servo_max)  // RQ10
        else $error("servo gain not at maximum");

    // servo ends into a frozen mode
    sequence s_servo_leave;
        STATUS.servo_active ##1 (!STATUS.servo_active && q.agc_state == ST_HOLD);
    endsequence

    // gain after servo is the one stored before it
    property p_servo_exit;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        s_servo_leave |-> STATUS.gain_step == $past(q.gain_q, 2);
    endproperty
    a_servo_exit: assert property (p_servo_exit)  // RQ10
        else $error("stored gain lost after servo");

    property p_corner;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        1'h1 |=> STATUS.corner == $past({CTRL.filter_corner_sel1,
                                         CTRL.filter_corner_sel0});
    endproperty
    a_corner: assert property (p_corner)  // RQ19
        else $error("corner select not followed");

    property p_sense_off;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        !CTRL.bias_current_on |=> !STATUS.sense_on
                                  && STATUS.sense_code == `SENSE_OFF_CODE;
    endproperty
    a_sense_off: assert property (p_sense_off)  // RQ17
        else $error("sense current not switched off");

    property p_saturate;
        @(posedge CLK_SYS) disable iff (!RESET_N)
        q.gain_q <= `GAIN_MAX_EXT;
    endproperty
    a_saturate: assert property (p_saturate)  // RQ20
        else $error("gain step out of range");

endmodule : read_channel_gain_control
`default_nettype wire

/* tb/level_model.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// far side: head, read path and equalizer level comparators
module level_model (
    input  wire logic            [4:0] gain_step,  // gain applied by the block
    input  wire logic            [4:0] target,     // step giving 1.1 Vpp here
    output var  rcg_pkg::level_t       level       // comparator pair seen
);
    timeunit 1ns;
    timeprecision 1ns;
    import rcg_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    // amplitude tracks gain; both flags low only at the regulation point
    always_comb
    begin
        level.amp_too_small = (gain_step < target);
        level.amp_too_large = (gain_step > target);
    end
endmodule : level_model
`default_nettype wire

/* tb/read_channel_gain_control_tb_top.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// bench for the gain control block, short step intervals
module read_channel_gain_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rcg_pkg::*;
    localparam int UP    = 20;    // cycles per up step in sim
    localparam int DN    = 4;     // cycles per down step in sim
    localparam int LIMIT = 6000;  // cycle ceiling of the run
    logic        clk_sys;         // 20 MHz clock
    logic        reset_n;         // async reset
    ctrl_t       ctrl;            // control bits
    level_t      level;           // comparator levels from far side
    logic        freeze_n;        // freeze pin
    logic        write_window_n;  // low while writing
    out_t        status;          // settings driven out
    logic [4:0]  target;          // regulation point of the model
    logic [4:0]  held;            // gain seen when frozen
    logic [31:0] rng = 32'h00002C6A;  // xorshift state
    int          num_errors = 0;  // mismatches
    int          checked = 0;     // comparisons
    int          cycles = 0;      // timeout counter
    int          n;               // cycles taken by a ramp
    ////////////////////////////////////////////////////////////////////////////
    read_channel_gain_control #(
        .UP_STEP_CYC   (UP),
        .DOWN_STEP_CYC (DN)
    ) DUT (
        .CLK_SYS        (clk_sys),
        .RESET_N        (reset_n),
        .CTRL           (ctrl),
        .LEVEL          (level),
        .FREEZE_N       (freeze_n),
        .WRITE_WINDOW_N (write_window_n),
        .STATUS         (status)
    );
    level_model PARTNER (
        .gain_step (status.gain_step),
        .target    (target),
        .level     (level)
    );
    ////////////////////////////////////////////////////////////////////////////
    // clock
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            num_errors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    // expected vga source from the select pair
    function automatic vga_src_t exp_src(input ctrl_t c);
        if ({c.vga_source_sel1, c.vga_source_sel0} == 2'h0) return SRC_SERVO;
        if ({c.vga_source_sel1, c.vga_source_sel0} == 2'h2) return SRC_BIASFB;
        return SRC_MAIN;
    endfunction : exp_src
    // expected preamp gain, upper code bit means test gain
    function automatic preamp_t exp_pg(input ctrl_t c);
        if (c.preamp_gain_sel[1]) return PG_4DB_TEST;
        return preamp_t'(c.preamp_gain_sel);
    endfunction : exp_pg
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask : cyc
    // bounded wait for a gain value, then compare
    task automatic wait_gain(input logic [4:0] g, input int lim, output int k);
        k = 0;
        while (status.gain_step !== g && k < lim)
        begin
            @(negedge clk_sys);
            k++;
        end
        check("gain reached", 16'(g), 16'(status.gain_step));
    endtask : wait_gain
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        reset_n = 1'b0;
        ctrl = '0;
        freeze_n = 1'b1;
        write_window_n = 1'b1;
        target = 5'h00;
        cyc(8);
        check("reset gain", 16'h0015, 16'(status.gain_step));
        check("reset servo", 16'h0001, 16'(status.servo_active));
        reset_n = 1'b1;
        $display("test reset done");
        // static decode: corner codes first, then random words
        for (int k = 0; k < 40; k++)
        begin
            rng = xs(rng);
            ctrl = ctrl_t'(rng[22:0]);
            ctrl.manual_gain_select = 1'b1;
            write_window_n = rng[23];
            if (k < 4)
            begin
                {ctrl.vga_source_sel1, ctrl.vga_source_sel0} = 2'(k);
                {ctrl.filter_corner_sel1, ctrl.filter_corner_sel0} = 2'(k);
                ctrl.preamp_gain_sel = 2'(k);
                ctrl.sense_code = 7'h7F;
                ctrl.bias_current_on = k[0];
            end
            cyc(1);
            check("vga_src", 16'(exp_src(ctrl)), 16'(status.vga_src));
            check("servo_active", 16'(exp_src(ctrl) == SRC_SERVO),
                  16'(status.servo_active));
            check("preamp", 16'(exp_pg(ctrl)), 16'(status.preamp));
            check("corner", 16'({ctrl.filter_corner_sel1, ctrl.filter_corner_sel0}),
                  16'(status.corner));
            check("hpf_on", 16'(ctrl.hpf_enable), 16'(status.hpf_on));
            check("sense_on", 16'(ctrl.bias_current_on), 16'(status.sense_on));
            check("sense_code", ctrl.bias_current_on ? 16'(ctrl.sense_code) : 16'h0,
                  16'(status.sense_code));
            check("sense_x2", 16'(ctrl.bias_current_range_x2), 16'(status.sense_range_x2));
            check("manual gain", exp_src(ctrl) == SRC_SERVO ? 16'h15 : 16'(ctrl.manual_gain),
                  16'(status.gain_step));
        end
        $display("test decode done");
        // loop ramps on the main vga source
        ctrl = '0;
        ctrl.vga_source_sel0 = 1'b1;
        write_window_n = 1'b1;
        wait_gain(5'h00, 400, n);
        target = 5'h1F;
        wait_gain(5'h0F, 15 * (UP + 3) + 5, n);
        check("up ramp not early", 16'h1, 16'(n >= 15 * UP));
        cyc(3 * UP);
        check("top saturates", 16'h0F, 16'(status.gain_step));
        ctrl.gain_ceiling_extend = 1'b1;
        wait_gain(5'h15, 6 * (UP + 3) + 5, n);
        cyc(3 * UP);
        check("extended top", 16'h15, 16'(status.gain_step));
        target = 5'h00;
        wait_gain(5'h00, 21 * (DN + 3) + 5, n);
        check("down ramp not early", 16'h1, 16'(n >= 21 * DN));
        cyc(5 * DN);
        check("bottom saturates", 16'h00, 16'(status.gain_step));
        $display("test ramp done");
        // regulation point held by the model
        target = 5'h08;
        wait_gain(5'h08, 8 * (UP + 3) + 5, n);
        cyc(3 * UP);
        check("regulated", 16'h08, 16'(status.gain_step));
        $display("test regulate done");
        // freeze by pin, then by writing
        target = 5'h14;
        cyc(2 * UP);
        freeze_n = 1'b0;
        cyc(1);
        held = status.gain_step;
        cyc(4 * UP);
        check("pin freeze", 16'(held), 16'(status.gain_step));
        check("frozen flag", 16'h1, 16'(status.agc_frozen));
        freeze_n = 1'b1;
        write_window_n = 1'b0;
        cyc(4 * UP);
        check("write freeze", 16'(held), 16'(status.gain_step));
        $display("test freeze done");
        // servo by select bits, stored gain kept
        ctrl.vga_source_sel0 = 1'b0;
        cyc(1);
        check("servo max gain", 16'h15, 16'(status.gain_step));
        cyc(2 * UP);
        ctrl.vga_source_sel0 = 1'b1;
        cyc(1);
        check("gain restored", 16'(held), 16'(status.gain_step));
        // servo by pin with role set first
        ctrl.freeze_pin_role = 1'b1;
        cyc(1);
        freeze_n = 1'b0;
        cyc(1);
        check("pin servo", 16'h1, 16'(status.servo_active));
        check("pin servo src", 16'(SRC_SERVO), 16'(status.vga_src));
        check("pin servo gain", 16'h15, 16'(status.gain_step));
        freeze_n = 1'b1;
        cyc(1);
        check("pin servo off", 16'h0, 16'(status.servo_active));
        check("pin gain restored", 16'(held), 16'(status.gain_step));
        // loop resumes once writing ends
        write_window_n = 1'b1;
        ctrl.freeze_pin_role = 1'b0;
        wait_gain(5'h14, 12 * (UP + 3) + 5, n);
        $display("test servo done");
        wrap_up();
    end
endmodule : read_channel_gain_control_tb_top
`default_nettype wire
